// [hw/ndfs_damp_freq.sv]
`timescale 1ns/1ps
`include "ndfs_defs.svh"

// ------------------------------------------------------------------
// Damping frequency check: validity and effective value.
// ------------------------------------------------------------------
module ndfs_damp_freq (
   // Raw setting in 0.1 Hz.
   input wire logic [15:0] raw,
   // Filter usable and effective setting.
   output logic valid,
   output logic [15:0] eff
);

   // A setting below 1.0 Hz disables the filter, and the value above the top
   // of the range is limited rather than refused so writes never vanish.
   always_comb begin
      valid = (raw >= `NDFS_DAMP_MIN);
      eff = (raw > `NDFS_DAMP_MAX) ? `NDFS_DAMP_MAX : raw;
      if (!valid) begin
         eff = 16'h0000;
      end
   end

endmodule : ndfs_damp_freq

// [hw/ndfs_defs.svh]
`ifndef NDFS_DEFS_SVH
`define NDFS_DEFS_SVH

// Register byte offsets (one aligned 32-bit word each).
`define NDFS_OFF_N4_FREQ 8'h00
`define NDFS_OFF_N4_WIDTH 8'h04
`define NDFS_OFF_N4_DEPTH 8'h08
`define NDFS_OFF_MODE 8'h0C
`define NDFS_OFF_D1_FREQ 8'h10
`define NDFS_OFF_D2_FREQ 8'h14
`define NDFS_OFF_D3_FREQ 8'h18
`define NDFS_OFF_D4_FREQ 8'h1C
`define NDFS_OFF_CTRL 8'h20
`define NDFS_OFF_STATUS 8'h24

// Control register fields.
`define NDFS_CTRL_TWO_DOF 0
`define NDFS_CTRL_ADAPT 1
`define NDFS_CTRL_ADAPT_DEPTH 2

// Status register fields.
`define NDFS_ST_ACTIVE_LSB 0
`define NDFS_ST_PENDING_LSB 4
`define NDFS_ST_N4_EN 8

// Reset values.
`define NDFS_RST_N4_FREQ 16'h1388
`define NDFS_RST_N4_WIDTH 16'h0002
`define NDFS_RST_N4_DEPTH 16'h0000
`define NDFS_RST_MODE 16'h0000
`define NDFS_RST_DAMP 16'h0000

// Setting ranges.
`define NDFS_N4_FREQ_MIN 16'h0032
`define NDFS_N4_FREQ_OFF 16'h1388
`define NDFS_N4_WIDTH_MAX 16'h0014
`define NDFS_N4_DEPTH_MAX 16'h0063
`define NDFS_MODE_MAX 16'h0003
`define NDFS_DAMP_MIN 16'h000A
`define NDFS_DAMP_MAX 16'h07D0

// Command sampling period and clock.
`define NDFS_SAMPLE_PERIOD_NS 166000
`define NDFS_CLK_PERIOD_NS 5
`define NDFS_SAMPLE_CYCLES (`NDFS_SAMPLE_PERIOD_NS / `NDFS_CLK_PERIOD_NS)

`endif

// [hw/ndfs_pkg.sv]
package ndfs_pkg;

   // --------------------------------------------------------------
   // Types
   // --------------------------------------------------------------

   // Command activity tracker, one-hot.
   typedef enum logic [1:0] {
      NDFS_CMD_IDLE = 2'b01,
      NDFS_CMD_RUN = 2'b10
   } ndfs_cmd_state_t;

   // Software control bits.
   typedef struct packed {
      logic adapt_depth;
      logic adapt;
      logic two_dof;
   } ndfs_ctrl_t;

   // Host-side levels caught once per sampling period.
   typedef struct packed {
      logic sel1;
      logic sel0;
      logic dir_neg;
      logic cnt_nz;
   } ndfs_sample_t;

endpackage : ndfs_pkg

// [hw/ndfs_sel_decode.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Damping filter selection decode.
// ------------------------------------------------------------------
module ndfs_sel_decode (
   // Configuration.
   input wire logic [1:0] mode,
   input wire logic two_dof,
   // Sampled host levels.
   input wire logic sel0,
   input wire logic sel1,
   input wire logic dir_neg,
   // One bit per damping filter, bit 0 is the first.
   output logic [3:0] mask
);

   // Two-degree-of-freedom control allows a single filter at a time.
   always_comb begin
      mask = 4'h0;
      case (mode)
         2'd0: begin
            mask = two_dof ? 4'h1 : 4'h3;
         end
         2'd1: begin
            if (two_dof) begin
               mask = sel0 ? 4'h2 : 4'h1;
            end else begin
               mask = sel0 ? 4'hA : 4'h5;
            end
         end
         2'd2: begin
            mask = 4'h1 << {sel1, sel0};
         end
         default: begin
            if (two_dof) begin
               mask = dir_neg ? 4'h2 : 4'h1;
            end else begin
               mask = dir_neg ? 4'h2 : 4'h5;
            end
         end
      endcase
   end

endmodule : ndfs_sel_decode

// [hw/ndfs_top.sv]
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "ndfs_defs.svh"

module ndfs_top #(
   parameter int unsigned SAMPLE_CYCLES = `NDFS_SAMPLE_CYCLES
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   // Host controller levels.
   input wire logic damp_select_in0,
   input wire logic damp_select_in1,
   input wire logic cmd_dir_neg,
   input wire logic [15:0] cmd_pulse_cnt,
   input wire logic pos_complete,
   // Adaptive estimator results.
   input wire logic adapt_freq2_vld,
   input wire logic [15:0] adapt_freq2,
   input wire logic adapt_depth_vld,
   input wire logic [15:0] adapt_depth,
   // Filter configuration outputs.
   output logic notch4_en,
   output logic [15:0] notch4_freq,
   output logic [15:0] notch4_width,
   output logic [15:0] notch4_depth,
   output logic [3:0] damp_en,
   output logic [63:0] damp_freq,
   output logic fast_release
);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------

   logic [15:0] n4_freq_q, n4_freq_d;
   logic [15:0] n4_width_q, n4_width_d;
   logic [15:0] n4_depth_q, n4_depth_d;
   logic [15:0] mode_q, mode_d;
   logic [15:0] dfreq_q [4];
   logic [15:0] dfreq_d [4];
   ndfs_pkg::ndfs_ctrl_t ctrl_q, ctrl_d;
   logic [31:0] rd_data_q, rd_data_d;
   logic [3:0] active_q, active_d;
   logic [3:0] pending_q, pending_d;
   logic [15:0] wv;

   // Out-of-range notch and mode writes are dropped, damping frequencies are kept as written; an
   // estimator result lands in the same cycle as a write and wins over it.
   always_comb begin
      wv = wr_data[15:0];
      n4_freq_d = n4_freq_q;
      n4_width_d = n4_width_q;
      n4_depth_d = n4_depth_q;
      mode_d = mode_q;
      dfreq_d = dfreq_q;
      ctrl_d = ctrl_q;
      if (wr_en) begin
         if (addr == `NDFS_OFF_N4_FREQ) begin
            if (wv >= `NDFS_N4_FREQ_MIN && wv <= `NDFS_N4_FREQ_OFF) begin
               n4_freq_d = wv;
            end
         end else if (addr == `NDFS_OFF_N4_WIDTH) begin
            if (wv <= `NDFS_N4_WIDTH_MAX) begin
               n4_width_d = wv;
            end
         end else if (addr == `NDFS_OFF_N4_DEPTH) begin
            if (wv <= `NDFS_N4_DEPTH_MAX) begin
               n4_depth_d = wv;
            end
         end else if (addr == `NDFS_OFF_MODE) begin
            if (wv <= `NDFS_MODE_MAX) begin
               mode_d = wv;
            end
         end else if (addr == `NDFS_OFF_D1_FREQ) begin
            dfreq_d[0] = wv;
         end else if (addr == `NDFS_OFF_D2_FREQ) begin
            dfreq_d[1] = wv;
         end else if (addr == `NDFS_OFF_D3_FREQ) begin
            dfreq_d[2] = wv;
         end else if (addr == `NDFS_OFF_D4_FREQ) begin
            dfreq_d[3] = wv;
         end else if (addr == `NDFS_OFF_CTRL) begin
            ctrl_d = wr_data[2:0];
         end
      end
      if (ctrl_q.adapt && adapt_freq2_vld && adapt_freq2 >= `NDFS_N4_FREQ_MIN
          && adapt_freq2 <= `NDFS_N4_FREQ_OFF) begin
         n4_freq_d = adapt_freq2;
      end
      if (ctrl_q.adapt_depth && adapt_depth_vld && adapt_depth <= `NDFS_N4_DEPTH_MAX) begin
         n4_depth_d = adapt_depth;
      end
   end

   // Read data stand in the cycle after the strobe only; unmapped reads give zero.
   always_comb begin
      rd_data_d = 32'h0000_0000;
      if (rd_en) begin
         if (addr == `NDFS_OFF_N4_FREQ) begin
            rd_data_d = {16'h0000, n4_freq_q};
         end else if (addr == `NDFS_OFF_N4_WIDTH) begin
            rd_data_d = {16'h0000, n4_width_q};
         end else if (addr == `NDFS_OFF_N4_DEPTH) begin
            rd_data_d = {16'h0000, n4_depth_q};
         end else if (addr == `NDFS_OFF_MODE) begin
            rd_data_d = {16'h0000, mode_q};
         end else if (addr == `NDFS_OFF_D1_FREQ) begin
            rd_data_d = {16'h0000, dfreq_q[0]};
         end else if (addr == `NDFS_OFF_D2_FREQ) begin
            rd_data_d = {16'h0000, dfreq_q[1]};
         end else if (addr == `NDFS_OFF_D3_FREQ) begin
            rd_data_d = {16'h0000, dfreq_q[2]};
         end else if (addr == `NDFS_OFF_D4_FREQ) begin
            rd_data_d = {16'h0000, dfreq_q[3]};
         end else if (addr == `NDFS_OFF_CTRL) begin
            rd_data_d = {29'h0000_0000, ctrl_q};
         end else if (addr == `NDFS_OFF_STATUS) begin
            rd_data_d[`NDFS_ST_ACTIVE_LSB +: 4] = active_q;
            rd_data_d[`NDFS_ST_PENDING_LSB +: 4] = pending_q;
            rd_data_d[`NDFS_ST_N4_EN] = (n4_freq_q != `NDFS_N4_FREQ_OFF);
         end
      end
   end

   // Register storage.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         n4_freq_q <= `NDFS_RST_N4_FREQ;
         n4_width_q <= `NDFS_RST_N4_WIDTH;
         n4_depth_q <= `NDFS_RST_N4_DEPTH;
         mode_q <= `NDFS_RST_MODE;
         for (int i = 0; i < 4; i++) begin
            dfreq_q[i] <= `NDFS_RST_DAMP;
         end
         ctrl_q <= '0;
         rd_data_q <= 32'h0000_0000;
      end else begin
         n4_freq_q <= n4_freq_d;
         n4_width_q <= n4_width_d;
         n4_depth_q <= n4_depth_d;
         mode_q <= mode_d;
         dfreq_q <= dfreq_d;
         ctrl_q <= ctrl_d;
         rd_data_q <= rd_data_d;
      end
   end

   // ----------------------------------------------------------------
   // Command sampling tick
   // ----------------------------------------------------------------

   logic [31:0] tick_cnt_q, tick_cnt_d;
   logic tick_q, tick_d;

   // One-cycle enable at the command sampling period.
   always_comb begin
      tick_d = (tick_cnt_q == SAMPLE_CYCLES - 1);
      tick_cnt_d = tick_d ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
      end
   end

   // ----------------------------------------------------------------
   // Selection and deferred switching
   // ----------------------------------------------------------------

   ndfs_pkg::ndfs_sample_t smp_q, smp_d;
   ndfs_pkg::ndfs_cmd_state_t cmd_q, cmd_d;
   logic [3:0] sel_mask;
   logic fast_q, fast_d;
   logic start_evt;

   ndfs_sel_decode u_decode (
      .mode(mode_q[1:0]),
      .two_dof(ctrl_q.two_dof),
      .sel0(smp_q.sel0),
      .sel1(smp_q.sel1),
      .dir_neg(smp_q.dir_neg),
      .mask(sel_mask)
   );

   // The host levels are caught once per period so the selection cannot
   // chatter inside a period; the pending mask follows the caught levels one cycle later.
   always_comb begin
      smp_d = smp_q;
      if (tick_q) begin
         smp_d.sel0 = damp_select_in0;
         smp_d.sel1 = damp_select_in1;
         smp_d.dir_neg = cmd_dir_neg;
         smp_d.cnt_nz = (cmd_pulse_cnt != 16'h0000);
      end
      pending_d = sel_mask;
   end

   // A command start is the count going from zero to nonzero between two
   // samples; switching is only safe then, with the axis in position.
   always_comb begin
      cmd_d = cmd_q;
      start_evt = 1'b0;
      active_d = active_q;
      fast_d = 1'b0;
      case (cmd_q)
         ndfs_pkg::NDFS_CMD_IDLE: begin
            if (tick_q && cmd_pulse_cnt != 16'h0000) begin
               cmd_d = ndfs_pkg::NDFS_CMD_RUN;
               start_evt = 1'b1;
            end
         end
         ndfs_pkg::NDFS_CMD_RUN: begin
            if (tick_q && cmd_pulse_cnt == 16'h0000) begin
               cmd_d = ndfs_pkg::NDFS_CMD_IDLE;
            end
         end
         default: begin
            cmd_d = ndfs_pkg::NDFS_CMD_IDLE;
         end
      endcase
      if (start_evt && pos_complete) begin
         active_d = pending_q;
         fast_d = (pending_q != active_q);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         smp_q <= '0;
         cmd_q <= ndfs_pkg::NDFS_CMD_IDLE;
         pending_q <= 4'h3;
         active_q <= 4'h3;
         fast_q <= 1'b0;
      end else begin
         smp_q <= smp_d;
         cmd_q <= cmd_d;
         pending_q <= pending_d;
         active_q <= active_d;
         fast_q <= fast_d;
      end
   end

   // ----------------------------------------------------------------
   // Filter outputs
   // ----------------------------------------------------------------

   logic [3:0] dvalid;
   logic [15:0] deff [4];
   logic [3:0] damp_en_q, damp_en_d;
   logic [63:0] damp_freq_q, damp_freq_d;
   logic n4_en_q, n4_en_d;

   for (genvar g = 0; g < 4; g++) begin : g_damp
      ndfs_damp_freq u_freq (
         .raw(dfreq_q[g]),
         .valid(dvalid[g]),
         .eff(deff[g])
      );
   end

   // A selected filter with a disabling setting simply stays off.
   always_comb begin
      damp_en_d = active_q & dvalid;
      for (int i = 0; i < 4; i++) begin
         damp_freq_d[i*16 +: 16] = deff[i];
      end
      n4_en_d = (n4_freq_q != `NDFS_N4_FREQ_OFF);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         damp_en_q <= 4'h0;
         damp_freq_q <= 64'h0000_0000_0000_0000;
         n4_en_q <= 1'b0;
      end else begin
         damp_en_q <= damp_en_d;
         damp_freq_q <= damp_freq_d;
         n4_en_q <= n4_en_d;
      end
   end

   assign rd_data = rd_data_q;
   assign notch4_en = n4_en_q;
   assign notch4_freq = n4_freq_q;
   assign notch4_width = n4_width_q;
   assign notch4_depth = n4_depth_q;
   assign damp_en = damp_en_q;
   assign damp_freq = damp_freq_q;
   assign fast_release = fast_q;

endmodule : ndfs_top

// [verification/ndfs_host_model.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Host controller model: selects, direction and command pulses.
// ------------------------------------------------------------
module ndfs_host_model #(
   parameter int unsigned P = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Requests from the bench.
   input wire logic start,
   input wire logic want_s0,
   input wire logic want_s1,
   input wire logic want_neg,
   input wire logic want_pc,
   // Host pins.
   output logic sel0,
   output logic sel1,
   output logic dir_neg,
   output logic pos_complete,
   output logic [15:0] cmd_cnt,
   output logic busy
);
   int unsigned left_q;

   // Levels are latched at the request and held through the command, so they are steady
   // at every tick; four idle periods precede the pulses so the pending set settles.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         left_q <= 0;
         {sel1, sel0, dir_neg, pos_complete} <= 4'h0;
         cmd_cnt <= 16'h0000;
      end else begin
         if (start && left_q == 0) begin
            left_q <= 6 * P;
            {sel1, sel0, dir_neg} <= {want_s1, want_s0, want_neg};
            pos_complete <= want_pc;
         end else if (left_q != 0) begin
            left_q <= left_q - 1;
         end
         cmd_cnt <= (left_q != 0 && left_q <= 2 * P) ? 16'h0005 : 16'h0000;
      end
   end
   assign busy = (left_q != 0);
endmodule : ndfs_host_model

// [verification/ndfs_top_sva.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Checker for the filter select block.
// ------------------------------------------------------------
module ndfs_top_sva #(
   parameter int unsigned SAMPLE_CYCLES = 8
) (
   // Clock, reset and register port.
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rd_data,
   // Host levels.
   input wire logic [15:0] cmd_pulse_cnt,
   input wire logic pos_complete,
   // Filter configuration.
   input wire logic notch4_en,
   input wire logic [15:0] notch4_freq,
   input wire logic [15:0] notch4_width,
   input wire logic [15:0] notch4_depth,
   input wire logic [3:0] damp_en,
   input wire logic [63:0] damp_freq,
   input wire logic fast_release
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // Stability guard lets the enable lag its frequency by one register stage.
   AST_N4_OFF: assert property (
      $stable(notch4_freq) |-> notch4_en == (notch4_freq != 16'h1388))
      else $error("Notch enable disagrees with frequency.");
   AST_N4_RANGE: assert property (
      notch4_freq >= 16'h0032 && notch4_freq <= 16'h1388)
      else $error("Notch frequency out of range.");
   AST_WIDTH_RANGE: assert property (
      notch4_width <= 16'h0014) else $error("Notch width out of range.");
   AST_DEPTH_RANGE: assert property (
      notch4_depth <= 16'h0063) else $error("Notch depth out of range.");
   AST_MODE_READ: assert property (
      $past(rd_en) && $past(addr) == 8'h0C |-> rd_data[31:2] == 30'h0000_0000)
      else $error("Mode reads above three.");
   AST_AT_MOST_TWO: assert property (
      $countones(damp_en) <= 2) else $error("More than two damping filters run.");
   // The pulse follows the tick cycle in which the start and in-position were seen.
   AST_SWITCH_CAUSE: assert property (
      fast_release |-> $past(pos_complete) && $past(cmd_pulse_cnt) != 16'h0000)
      else $error("Switch without a start.");
   AST_RELEASE_PULSE: assert property (
      fast_release |=> !fast_release) else $error("Fast release longer than a cycle.");
   // The running set moves one cycle after a switch pulse or two after a write.
   AST_EN_HELD: assert property (
      $changed(damp_en) |-> $past(fast_release) || $past(wr_en, 2))
      else $error("Damping set changed without cause.");
   for (genvar i = 0; i < 4; i++) begin : g_damp
      AST_DAMP_VALID: assert property (
         damp_en[i] |-> damp_freq[16*i +: 16] inside {[16'h000A:16'h07D0]})
         else $error("Running filter has a bad frequency.");
   end

   // Main scenarios.
   COV_SWITCH: cover property (fast_release);
   COV_FOURTH: cover property (damp_en == 4'h8);
   COV_NOTCH_ON: cover property (notch4_en);
endmodule : ndfs_top_sva

bind ndfs_top ndfs_top_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_sva (
   .clk(clk), .resetn(resetn), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data(rd_data), .cmd_pulse_cnt(cmd_pulse_cnt), .pos_complete(pos_complete),
   .notch4_en(notch4_en), .notch4_freq(notch4_freq), .notch4_width(notch4_width),
   .notch4_depth(notch4_depth), .damp_en(damp_en), .damp_freq(damp_freq),
   .fast_release(fast_release));

// [verification/ndfs_top_tb_top.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Bench for the notch and damping filter select block.
// ------------------------------------------------------------
module ndfs_top_tb_top;
   localparam int unsigned SC = 8;
   localparam logic [15:0] RST [7] = '{16'h1388, 16'h0002, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000};
   // Mode, two-dof, sel1, sel0, negative, expected set.
   localparam logic [9:0] TAB [15] = '{10'h201, 10'h222, 10'h244, 10'h268, 10'h2C4, 10'h105,
      10'h16A, 10'h1A2, 10'h181, 10'h305, 10'h312, 10'h381, 10'h392, 10'h0F1, 10'h073};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h0000_0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic go = 1'b0, hs0 = 1'b0, hs1 = 1'b0, hneg = 1'b0, hpc = 1'b0;
   logic a_fv = 1'b0, a_dv = 1'b0;
   logic [15:0] a_f = 16'h0000, a_d = 16'h0000;
   logic [31:0] rd_data;
   logic dsel0, dsel1, dneg, dpc, busy, n4_en, frel;
   logic [15:0] dcnt, n4_f, n4_w, n4_d;
   logic [3:0] den;
   logic [63:0] dfreq;
   int n_fail = 0;
   int total_checks = 0;
   int n_rel = 0;

   // Clock.
   always #2.5 clk = ~clk;

   // Counts fast release pulses so scenarios can judge how many switches happened.
   always @(posedge clk) begin
      if (frel === 1'b1) begin
         n_rel++;
      end
   end

   ndfs_host_model #(.P(SC)) host (.clk(clk), .resetn(resetn), .start(go), .want_s0(hs0),
      .want_s1(hs1), .want_neg(hneg), .want_pc(hpc), .sel0(dsel0), .sel1(dsel1),
      .dir_neg(dneg), .pos_complete(dpc), .cmd_cnt(dcnt), .busy(busy));

   ndfs_top #(.SAMPLE_CYCLES(SC)) dut (.clk(clk), .resetn(resetn), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .damp_select_in0(dsel0), .damp_select_in1(dsel1), .cmd_dir_neg(dneg),
      .cmd_pulse_cnt(dcnt), .pos_complete(dpc), .adapt_freq2_vld(a_fv), .adapt_freq2(a_f),
      .adapt_depth_vld(a_dv), .adapt_depth(a_d), .notch4_en(n4_en), .notch4_freq(n4_f),
      .notch4_width(n4_w), .notch4_depth(n4_d), .damp_en(den), .damp_freq(dfreq),
      .fast_release(frel));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= {16'h0000, d};
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rd_data, exp);
   endtask : rd

   // One command from the host, then settle.
   task automatic run(input logic a1, input logic a0, input logic n, input logic p);
      int k;
      @(posedge clk);
      {hs1, hs0, hneg, hpc} <= {a1, a0, n, p};
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
      for (k = 0; k < 200 && busy === 1'b1; k++) @(posedge clk);
      if (k == 200) begin
         n_fail++;
         $display("ERROR %0t command did not finish", $time);
      end
      repeat (4) @(posedge clk);
      #1;
   endtask : run

   task automatic t_reset;
      for (int i = 0; i < 7; i++) rd(8'(4 * i), {16'h0000, RST[i]});
      rd(8'h40, 32'h0000_0000);
      rd(8'h24, 32'h0000_0033);
      chk({31'h0000_0000, n4_en}, 32'h0000_0000);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_regs;
      wr(8'h00, 16'h0031);
      rd(8'h00, 32'h0000_1388);
      wr(8'h00, 16'h0032);
      wr(8'h00, 16'h1389);
      rd(8'h00, 32'h0000_0032);
      chk({31'h0000_0000, n4_en}, 32'h0000_0001);
      wr(8'h04, 16'h0015);
      rd(8'h04, 32'h0000_0002);
      wr(8'h04, 16'h0014);
      wr(8'h08, 16'h0064);
      rd(8'h08, 32'h0000_0000);
      wr(8'h08, 16'h0063);
      wr(8'h0C, 16'h0004);
      rd(8'h0C, 32'h0000_0000);
      wr(8'h0C, 16'h0003);
      rd(8'h0C, 32'h0000_0003);
      chk({n4_w, n4_d}, 32'h0014_0063);
      wr(8'h00, 16'h1388);
      rd(8'h00, 32'h0000_1388);
      chk({31'h0000_0000, n4_en}, 32'h0000_0000);
      $display("t_regs done");
   endtask : t_regs

   // Estimator results load the notch only while the adaptive bits are set.
   task automatic t_adapt;
      for (int j = 0; j < 2; j++) begin
         wr(8'h20, 16'(6 * j));
         @(posedge clk);
         {a_f, a_d} <= 32'h04D2_0028;
         {a_fv, a_dv} <= 2'h3;
         @(posedge clk);
         {a_fv, a_dv} <= 2'h0;
         repeat (3) @(posedge clk);
         #1 chk({n4_f, n4_d}, (j == 1) ? 32'h04D2_0028 : 32'h1388_0063);
      end
      $display("t_adapt done");
   endtask : t_adapt

   task automatic t_select;
      logic [9:0] e;
      for (int i = 0; i < 4; i++) wr(8'(16 + 4 * i), 16'h0064);
      for (int i = 0; i < 15; i++) begin
         e = TAB[i];
         wr(8'h0C, {14'h0000, e[9:8]});
         wr(8'h20, {15'h0000, e[7]});
         run(e[6], e[5], e[4], 1'b1);
         chk({28'h000_0000, den}, {28'h000_0000, e[3:0]});
      end
      $display("t_select done");
   endtask : t_select

   task automatic t_freq;
      wr(8'h10, 16'h0009);
      rd(8'h10, 32'h0000_0009);
      chk({28'h000_0000, den}, 32'h0000_0002);
      wr(8'h10, 16'h000A);
      rd(8'h10, 32'h0000_000A);
      chk({dfreq[15:0], 12'h000, den}, 32'h000A_0003);
      wr(8'h10, 16'h09C4);
      rd(8'h10, 32'h0000_09C4);
      chk(dfreq[31:0], 32'h0064_07D0);
      $display("t_freq done");
   endtask : t_freq

   // A start without positioning complete must leave the set alone.
   task automatic t_refuse;
      int r;
      wr(8'h0C, 16'h0002);
      r = n_rel;
      run(1'b1, 1'b1, 1'b0, 1'b0);
      chk({28'h000_0000, den}, 32'h0000_0003);
      rd(8'h24, 32'h0000_0183);
      chk(32'(n_rel - r), 32'h0000_0000);
      run(1'b1, 1'b1, 1'b0, 1'b1);
      chk({28'h000_0000, den}, 32'h0000_0008);
      rd(8'h24, 32'h0000_0188);
      chk(32'(n_rel - r), 32'h0000_0001);
      $display("t_refuse done");
   endtask : t_refuse

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict

   // Main sequence.
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_regs();
      t_adapt();
      t_select();
      t_freq();
      t_refuse();
      give_verdict();
   end

   // Watchdog, well beyond the expected run of about eleven hundred cycles.
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("ERROR %0t watchdog ran out", $time);
      give_verdict();
   end
endmodule : ndfs_top_tb_top
